/* File: shared/pqm_pkg.sv */
package pqm_pkg;

  // ----------------------------------------------------------------
  // Register indexes (printed offsets; byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [15:0] PQM_IDX_AUTONOMY = 16'h018B;
  localparam logic [15:0] PQM_IDX_POWER_MODE = 16'h018C;
  localparam logic [15:0] PQM_IDX_SNR = 16'h0197;
  localparam logic [15:0] PQM_IDX_QUALITY = 16'h0198;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PQM_BIT_LPS_TX_EN = 0;
  localparam int PQM_BIT_SLEEP_EN = 1;
  localparam int PQM_BIT_AUTONOMOUS = 6;
  localparam int PQM_BIT_FORCE_NORMAL = 0;
  localparam int PQM_BIT_SLEEP_REQ = 1;
  localparam int PQM_SNR_MSB = 8;
  localparam int PQM_CLASS_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] PQM_RST_AUTO_RSVD = 9'h000;
  localparam logic [3:0] PQM_RST_AUTO_MID = 4'h6;
  localparam logic PQM_RST_SLEEP_EN = 1'b1;
  localparam logic PQM_RST_LPS_TX_EN = 1'b0;
  localparam logic [13:0] PQM_RST_PWR_RSVD = 14'h0000;
  localparam logic PQM_RST_SLEEP_REQ = 1'b0;
  localparam logic PQM_RST_FORCE_NORMAL = 1'b0;
  localparam logic [8:0] PQM_RST_SNR = 9'h000;
  localparam logic [7:0] PQM_RST_QUALITY = 8'h00;
  // Edges after reset before the strap stage holds the pin level
  localparam logic [1:0] PQM_STRAP_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // Quality class thresholds and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PQM_QUAL_EXCELLENT_ABOVE = 8'd70;
  localparam logic [7:0] PQM_QUAL_POOR_BELOW = 8'd40;
  localparam logic [1:0] PQM_CLASS_NO_LINK = 2'h0;
  localparam logic [1:0] PQM_CLASS_POOR = 2'h1;
  localparam logic [1:0] PQM_CLASS_GOOD = 2'h2;
  localparam logic [1:0] PQM_CLASS_EXCELLENT = 2'h3;

  // Power states as seen from the state machine outside
  typedef enum logic [1:0] {
    PQM_PS_NORMAL,
    PQM_PS_STANDBY,
    PQM_PS_SLEEP,
    PQM_PS_OTHER
  } pqm_pstate_type;

endpackage

/* File: logic/pqm_regs.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
// Behaviour
// - Bit 6 picks autonomous; reset from strap
// - Autonomy bit reads zero after first access
// - Managed entered only at reset, never by write
// - Sleep enable picks Sleep or Standby
// - LPS code-groups only while enable bit set
// - Sleep request bit asks for LPS transmission
// - Force-normal bit drives Normal state
// - Force-normal clears only on Standby to Normal
// - SIGNAL_NOISE_RATIO_RESULT field is ten times dB, bits 8:0
// - Class field in bits 9:8, four classes
// - Quality value thresholds 70 and 40
// - Class derived from quality value while link up, no-link code otherwise
module pqm_regs
  import pqm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic strap_autonomous,
  input wire logic link_up,
  input wire logic [8:0] snr_measure,
  input wire logic [7:0] quality_measure,
  input wire logic [1:0] power_state,
  output logic autonomous_mode,
  output logic sleep_select,
  output logic lps_tx_allowed,
  output logic lps_tx_request,
  output logic force_normal
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strap_s1; // Strap synchroniser stage one
    logic strap_s2; // Strap synchroniser stage two
    logic link_s1; // Link status stage one
    logic link_s2; // Link status stage two
    logic [8:0] snr_s1; // SIGNAL_NOISE_RATIO_RESULT stage one
    logic [8:0] snr_s2; // SIGNAL_NOISE_RATIO_RESULT stage two
    logic [7:0] qual_s1; // Quality stage one
    logic [7:0] qual_s2; // Quality stage two
    logic [1:0] ps_s1; // Power state stage one
    logic [1:0] ps_s2; // Power state stage two
    logic [1:0] ps_prev; // Power state last cycle
    logic strap_taken; // Strap captured after reset
    logic [1:0] strap_cnt; // Synchroniser fill count
    logic autonomous; // Operating mode, 1 = autonomous
    logic auto_touched; // Autonomy bit accessed once
    logic [8:0] auto_rsvd; // Reserved upper bits
    logic [3:0] auto_mid; // Reserved middle bits
    logic sleep_en; // Sleep versus Standby
    logic lps_en; // LPS transmission allowed
    logic [13:0] pwr_rsvd; // Reserved power bits
    logic sleep_req; // Sleep request command
    logic force_norm; // Force-normal command
    logic [8:0] signal_noise_ratio_result; // SIGNAL_NOISE_RATIO_RESULT result
    logic [7:0] quality; // Quality value
    logic [1:0] qclass; // Quality class
    logic [31:0] rdata; // Read data
    logic ready; // Access answered
    logic err; // Unmapped access
  } pqm_state_type;

  pqm_state_type s_q;
  pqm_state_type s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Map a quality value onto its class code
  function automatic logic [1:0] quality_class(input logic [7:0] v,
                                               input logic up);
    if (!up)
      quality_class = PQM_CLASS_NO_LINK;
    else if (v > PQM_QUAL_EXCELLENT_ABOVE)
      quality_class = PQM_CLASS_EXCELLENT;
    else if (v >= PQM_QUAL_POOR_BELOW)
      quality_class = PQM_CLASS_GOOD;
    else
      quality_class = PQM_CLASS_POOR;
  endfunction

  // Compare a byte address with a register index
  function automatic logic hit(input logic [31:0] a,
                               input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'b00});
  endfunction

  logic setup;
  logic access;
  logic [15:0] wlo;

  // Phase decode and low write half gated by strobes
  always_comb
  begin
    setup = psel && !penable;
    access = psel && penable;
    wlo[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
    wlo[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Two-flop synchronisers on pins
    s_d.strap_s1 = strap_autonomous;
    s_d.strap_s2 = s_q.strap_s1;
    s_d.link_s1 = link_up;
    s_d.link_s2 = s_q.link_s1;
    s_d.snr_s1 = snr_measure;
    s_d.snr_s2 = s_q.snr_s1;
    s_d.qual_s1 = quality_measure;
    s_d.qual_s2 = s_q.qual_s1;
    s_d.ps_s1 = power_state;
    s_d.ps_s2 = s_q.ps_s1;
    s_d.ps_prev = s_q.ps_s2;
    // strap capture
    // Wait until the stages hold the pin, not their reset zero
    if (!s_q.strap_taken)
    begin
      if (s_q.strap_cnt == PQM_STRAP_SETTLE)
      begin
        s_d.strap_taken = 1'b1;
        s_d.autonomous = s_q.strap_s2;
      end
      else
        s_d.strap_cnt = s_q.strap_cnt + 2'h1;
    end
    s_d.signal_noise_ratio_result = s_q.snr_s2;
    s_d.quality = s_q.qual_s2;
    s_d.qclass = quality_class(s_q.qual_s2, s_q.link_s2);
    // clear only on Standby to Normal
    if (s_q.ps_prev == PQM_PS_STANDBY && s_q.ps_s2 == PQM_PS_NORMAL)
      s_d.force_norm = 1'b0;
    s_d.ready = 1'b0;
    s_d.err = 1'b0;
    // Setup phase answers next cycle
    if (setup)
    begin
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (hit(paddr, PQM_IDX_AUTONOMY))
      begin
        if (pwrite)
        begin
          if (pstrb[0])
          begin
            if (wlo[PQM_BIT_AUTONOMOUS])
              s_d.autonomous = 1'b1;
            s_d.auto_touched = 1'b1;
            s_d.auto_mid = wlo[5:2];
            s_d.sleep_en = wlo[PQM_BIT_SLEEP_EN];
            s_d.lps_en = wlo[PQM_BIT_LPS_TX_EN];
            s_d.auto_rsvd[0] = wlo[7];
          end
          if (pstrb[1])
            s_d.auto_rsvd[8:1] = wlo[15:8];
        end
        else
        begin
          s_d.rdata = {16'h0000, s_q.auto_rsvd, 1'b0, s_q.auto_mid,
                       s_q.sleep_en, s_q.lps_en};
          s_d.rdata[PQM_BIT_AUTONOMOUS] = s_q.autonomous &&
                                          !s_q.auto_touched;
          s_d.auto_touched = 1'b1;
        end
      end
      else if (hit(paddr, PQM_IDX_POWER_MODE))
      begin
        if (pwrite)
        begin
          if (pstrb[0])
          begin
            s_d.sleep_req = wlo[PQM_BIT_SLEEP_REQ];
            if (wlo[PQM_BIT_FORCE_NORMAL])
              s_d.force_norm = 1'b1;
            s_d.pwr_rsvd[5:0] = wlo[7:2];
          end
          if (pstrb[1])
            s_d.pwr_rsvd[13:6] = wlo[15:8];
        end
        else
          s_d.rdata = {16'h0000, s_q.pwr_rsvd, s_q.sleep_req,
                       s_q.force_norm};
      end
      else if (hit(paddr, PQM_IDX_SNR))
      begin
        if (!pwrite)
          s_d.rdata = {23'h000000, s_q.signal_noise_ratio_result};
      end
      else if (hit(paddr, PQM_IDX_QUALITY))
      begin
        if (!pwrite)
          s_d.rdata = {22'h000000, s_q.qclass, s_q.quality};
      end
      else
        // Unmapped address
        s_d.err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.auto_rsvd <= PQM_RST_AUTO_RSVD;
      s_q.auto_mid <= PQM_RST_AUTO_MID;
      s_q.sleep_en <= PQM_RST_SLEEP_EN;
      s_q.lps_en <= PQM_RST_LPS_TX_EN;
      s_q.pwr_rsvd <= PQM_RST_PWR_RSVD;
      s_q.sleep_req <= PQM_RST_SLEEP_REQ;
      s_q.force_norm <= PQM_RST_FORCE_NORMAL;
      s_q.signal_noise_ratio_result <= PQM_RST_SNR;
      s_q.quality <= PQM_RST_QUALITY;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    prdata = s_q.rdata;
    pready = s_q.ready;
    pslverr = s_q.err;
    autonomous_mode = s_q.autonomous;
    sleep_select = s_q.sleep_en;
    lps_tx_allowed = s_q.lps_en;
    lps_tx_request = s_q.sleep_req && s_q.lps_en;
    force_normal = s_q.force_norm;
  end

endmodule // pqm_regs

/* File: tb/pqm_regs_props.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bus timing and control output checks
// ------------------------------------------------------------
module pqm_regs_props
  import pqm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] power_state,
  input wire logic autonomous_mode,
  input wire logic sleep_select,
  input wire logic lps_tx_allowed,
  input wire logic lps_tx_request,
  input wire logic force_normal
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write setups to the two control registers
  logic wr_set;
  logic wr_auto;
  logic wr_pwr;
  // Class expected from the returned value
  logic [1:0] cls;
  assign wr_set = psel && !penable && pwrite && clk_en && pstrb[0];
  assign wr_auto = wr_set && paddr == 32'h0000062C;
  assign wr_pwr = wr_set && paddr == 32'h00000630;
  assign cls = prdata[7:0] > 8'h46 ? 2'h3 : prdata[7:0] < 8'h28 ? 2'h1 : 2'h2;
  AST_READY_NEXT: assert property (psel && !penable && clk_en |=> pready)
    else $error("pready missing after setup");
  AST_READY_ONE: assert property (pready && clk_en |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_REQ_GATED: assert property (lps_tx_request |-> lps_tx_allowed)
    else $error("sleep request without permission");
  AST_SLEEP_SEL: assert property (wr_auto |=> sleep_select == $past(pwdata[1]))
    else $error("sleep select not written");
  AST_LPS_EN: assert property (wr_auto |=> lps_tx_allowed == $past(pwdata[0]))
    else $error("transmit permission not written");
  AST_STAY_AUTO: assert property (autonomous_mode |=> autonomous_mode)
    else $error("left autonomous mode without reset");
  AST_FN_SET: assert property (wr_pwr && pwdata[0] |=> force_normal)
    else $error("force normal not set");
  AST_FN_CLEAR: assert property ($fell(force_normal) |-> power_state == 2'h0)
    else $error("force normal cleared outside normal");
  AST_CLASS: assert property (pready && !pwrite && paddr == 32'h00000660 &&
    prdata[9:8] != 2'h0 |-> prdata[9:8] == cls)
    else $error("class disagrees with value");
endmodule // pqm_regs_props

/* File: tb/pqm_regs_tb.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Register bench
// ------------------------------------------------------------
module pqm_regs_tb
  import pqm_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, er;
  logic strap_autonomous = 1'b1, link_up = 1'b0;
  logic [8:0] snr_measure = 9'h000;
  logic [7:0] quality_measure = 8'h00;
  logic [1:0] power_state = 2'h0;
  logic autonomous_mode, sleep_select, lps_tx_allowed;
  logic lps_tx_request, force_normal;
  logic [7:0] qv [7] = '{8'h27, 8'h28, 8'h46, 8'h47, 8'hFF, 8'h00, 8'h47};
  int errors = 0, comparisons = 0;
  always #2 pclk = ~pclk;
  pqm_regs dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .strap_autonomous,
    .link_up, .snr_measure, .quality_measure, .power_state, .autonomous_mode,
    .sleep_select, .lps_tx_allowed, .lps_tx_request, .force_normal);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, zero or more wait states
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1)
      errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Class worked out from link and value
  function automatic logic [1:0] cls_of(input logic up, input logic [7:0] v);
    if (!up)
      return 2'h0;
    return v > 8'h46 ? 2'h3 : v < 8'h28 ? 2'h1 : 2'h2;
  endfunction
  task summarize;
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #40000;
    errors++;
    summarize();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    xfer(0, 32'h62C, 32'h0);
    chk("autonomy", 32'h5A, rd);
    xfer(0, 32'h62C, 32'h0);
    chk("autonomy_again", 32'h1A, rd);
    xfer(1, 32'h62C, 32'h1);
    chk("mode", 32'h1, {31'h0, autonomous_mode});
    chk("sleep_sel", 32'h0, {31'h0, sleep_select});
    chk("lps_ok", 32'h1, {31'h0, lps_tx_allowed});
    xfer(0, 32'h65C, 32'h0);
    chk("noise_rst", 32'h0, rd);
    xfer(1, 32'h630, 32'h2);
    chk("lps_req", 32'h1, {31'h0, lps_tx_request});
    xfer(1, 32'h62C, 32'h0);
    chk("lps_gate", 32'h0, {31'h0, lps_tx_request});
    power_state <= 2'h1;
    xfer(1, 32'h630, 32'h1);
    chk("fn_set", 32'h1, {31'h0, force_normal});
    for (int s = 0; s < 4; s++)
    begin
      power_state <= s[0] ? 2'h0 : (s == 0 ? 2'h2 : 2'h1);
      repeat (8) @(posedge pclk);
      if (s == 1)
        chk("fn_hold", 32'h1, {31'h0, force_normal});
    end
    chk("fn_clear", 32'h0, {31'h0, force_normal});
    link_up <= 1'b1;
    snr_measure <= 9'h1F3;
    repeat (8) @(posedge pclk);
    xfer(1, 32'h65C, 32'hFFFF);
    xfer(0, 32'h65C, 32'h0);
    chk("noise", 32'h1F3, rd);
    for (int i = 0; i < 7; i++)
    begin
      link_up <= i < 6;
      quality_measure <= qv[i];
      repeat (8) @(posedge pclk);
      xfer(0, 32'h660, 32'h0);
      chk("quality", {22'h0, cls_of(i < 6, qv[i]), qv[i]}, rd);
    end
    xfer(1, 32'h634, 32'h1);
    chk("unmapped", 32'h1, {31'h0, er});
    strap_autonomous <= 1'b0;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("managed", 32'h0, {31'h0, autonomous_mode});
    summarize();
  end
endmodule // pqm_regs_tb
bind pqm_regs pqm_regs_props props_u (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .power_state, .autonomous_mode, .sleep_select, .lps_tx_allowed,
  .lps_tx_request, .force_normal);
